/* logic/srrc_clamp.sv */
`default_nettype none
module srrc_clamp #(
	parameter logic [9:0] INPUT_MIN_VALID    = srrc_pkg::IN_MIN_DEF,
	parameter logic [9:0] INPUT_NOMINAL_LOW  = srrc_pkg::IN_LO_DEF,
	parameter logic [9:0] INPUT_NOMINAL_HIGH = srrc_pkg::IN_HI_DEF,
	parameter logic [9:0] INPUT_MAX_VALID    = srrc_pkg::IN_MAX_DEF
) (
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       req_valid,
	input  wire logic [9:0] req_raw,
	input  wire logic       req_comp,
	input  wire logic       coef_we,
	input  wire logic       coef_erase,
	input  wire logic [8:0] coef_addr,
	input  wire logic [7:0] coef_wdata,
	output logic [7:0]      coef_rdata,
	output logic            res_valid,
	output logic [9:0]      res_data,
	output logic            res_err_low,
	output logic            res_err_high,
	output logic            res_underflow,
	output logic            res_overflow,
	output logic            res_nominal
);
	// coefficient store: coef_erase is left unused on purpose, the
	// region must survive an erase so calibration is never lost
	logic [7:0] coef_mem [srrc_pkg::COEF_BYTES];
	logic [7:0] next_coef_rdata;
	logic [8:0] wr_addr;
	logic [7:0] wr_data;
	logic       wr_en;

	always_comb begin
		next_coef_rdata = coef_mem[coef_addr];
		wr_en           = coef_we;
		wr_addr         = coef_addr;
		wr_data         = coef_wdata;
	end

	// no reset on the array: contents are undefined until written
	always_ff @(posedge clk) begin
		if (wr_en) begin
			coef_mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			coef_rdata <= 8'h00;
		end else begin
			coef_rdata <= next_coef_rdata;
		end
	end

	function automatic logic [15:0] join_bytes(
		input logic [7:0] lo,
		input logic [7:0] hi
	);
		join_bytes = {hi, lo};
	endfunction : join_bytes

	// gain is unsigned 8.8, offset signed in output lsbs
	logic [15:0] gain;
	logic [15:0] offs;

	always_comb begin
		gain = join_bytes(coef_mem[srrc_pkg::GAIN_ADDR],
			coef_mem[srrc_pkg::GAIN_ADDR + 9'h001]);
		offs = join_bytes(coef_mem[srrc_pkg::OFFS_ADDR],
			coef_mem[srrc_pkg::OFFS_ADDR + 9'h001]);
	end

	function automatic logic below_min(
		input logic [9:0] r
	);
		below_min = r < INPUT_MIN_VALID;
	endfunction : below_min

	function automatic logic above_max(
		input logic [9:0] r
	);
		above_max = r > INPUT_MAX_VALID;
	endfunction : above_max

	function automatic logic in_nominal(
		input logic [9:0] r
	);
		in_nominal = r >= INPUT_NOMINAL_LOW
			&& r <= INPUT_NOMINAL_HIGH;
	endfunction : in_nominal

	function automatic logic is_under(
		input logic signed [27:0] v
	);
		is_under = v < $signed({19'h00000, srrc_pkg::CODE_LOW});
	endfunction : is_under

	function automatic logic is_over(
		input logic signed [27:0] v
	);
		is_over = v > $signed({19'h00000, srrc_pkg::CODE_HIGH});
	endfunction : is_over

	function automatic logic [8:0] sat(
		input logic signed [27:0] v
	);
		if (is_under(v)) begin
			sat = srrc_pkg::CODE_LOW;
		end else if (is_over(v)) begin
			sat = srrc_pkg::CODE_HIGH;
		end else begin
			sat = v[8:0];
		end
	endfunction : sat

	// 28 bits hold 1023 times the largest gain with room for the sign
	function automatic logic signed [27:0] scale(
		input logic [9:0]  r,
		input logic [15:0] g
	);
		scale = ($signed({18'h00000, r}) * $signed({12'h000, g}))
			>>> srrc_pkg::GAIN_FRAC;
	endfunction : scale

	function automatic logic signed [27:0] add_offset(
		input logic signed [27:0] p,
		input logic [15:0]        o
	);
		add_offset = p + $signed({{12{o[15]}}, o});
	endfunction : add_offset

	logic signed [27:0] prod;
	logic signed [27:0] comp;

	always_comb begin
		prod = scale(req_raw, gain);
		comp = add_offset(prod, offs);
	end

	// range flags come from the raw code before any compensation, so an
	// out-of-range input can never pass for a saturated result
	logic next_el;
	logic next_eh;
	logic next_nom;

	always_comb begin
		next_el  = below_min(req_raw);
		next_eh  = above_max(req_raw);
		next_nom = in_nominal(req_raw);
	end

	logic       next_valid;
	logic [9:0] next_data;
	logic       next_uf;
	logic       next_of;

	always_comb begin
		next_valid = req_valid;
		next_uf    = 1'b0;
		next_of    = 1'b0;
		if (!req_comp) begin
			next_data = req_raw;
		end else if (next_el || next_eh) begin
			next_data = {1'b0, srrc_pkg::CODE_ERR};
		end else begin
			next_data = {1'b0, sat(comp)};
			next_uf   = is_under(comp);
			next_of   = is_over(comp);
		end
	end

	// results are recomputed every cycle; only res_valid marks a request
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			res_valid <= 1'b0;
		end else begin
			res_valid <= next_valid;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			res_data <= 10'h000;
		end else begin
			res_data <= next_data;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			res_err_low   <= 1'b0;
			res_err_high  <= 1'b0;
			res_underflow <= 1'b0;
			res_overflow  <= 1'b0;
			res_nominal   <= 1'b0;
		end else begin
			res_err_low   <= next_el;
			res_err_high  <= next_eh;
			res_underflow <= next_uf;
			res_overflow  <= next_of;
			res_nominal   <= next_nom;
		end
	end
endmodule : srrc_clamp
`default_nettype wire

/* logic/srrc_pkg.sv */
`default_nettype none
package srrc_pkg;
	localparam int RAW_W = 10;
	localparam int OUT_W = 9;
	localparam logic [9:0] RAW_FULL = 10'h3ff;
	// thresholds: plain defaults, real values are set through the srrc_clamp parameters
	localparam logic [9:0] IN_MIN_DEF = 10'h020;
	localparam logic [9:0] IN_LO_DEF = 10'h040;
	localparam logic [9:0] IN_HI_DEF = 10'h3c0;
	localparam logic [9:0] IN_MAX_DEF = 10'h3e0;
	localparam logic [8:0] CODE_ERR = 9'h000;
	localparam logic [8:0] CODE_FULL = 9'h1ff;
	localparam logic [8:0] CODE_LOW = 9'h001;
	localparam logic [8:0] CODE_HIGH = 9'h1fe;
	localparam int COEF_BYTES = 512;
	localparam int COEF_AW = 9;
	localparam int GAIN_FRAC = 8;
	localparam logic [15:0] GAIN_RESET = 16'h0080;
	localparam logic [15:0] OFFS_RESET = 16'h0000;
	localparam logic [8:0] GAIN_ADDR = 9'h000;
	localparam logic [8:0] OFFS_ADDR = 9'h002;
endpackage : srrc_pkg
`default_nettype wire

/* bench/srrc_clamp_monitor.sv */
`default_nettype none
module srrc_monitor (
	input wire logic       clk,
	input wire logic       arst_n,
	input wire logic       req_valid,
	input wire logic [9:0] req_raw,
	input wire logic       req_comp,
	input wire logic       res_valid,
	input wire logic [9:0] res_data,
	input wire logic       res_err_low,
	input wire logic       res_err_high,
	input wire logic       res_underflow,
	input wire logic       res_overflow
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	a_answer_lat:
		assert property (req_valid |=> res_valid) else $error("late");
	a_raw_pass:
		assert property (req_valid && !req_comp |=> res_data == $past(req_raw))
		else $error("raw");
	a_err_zero:
		assert property (req_valid && req_comp && req_raw < 10'h020
		|=> res_err_low && res_data == 10'h000) else $error("err");
	a_under_one:
		assert property (res_underflow |-> res_data == 10'h001) else $error("uf");
	a_over_cap:
		assert property (res_overflow |-> res_data == 10'h1fe) else $error("of");
	a_err_nosat:
		assert property (res_err_low |-> !res_underflow) else $error("sat");
	a_code_top:
		assert property (req_valid && req_comp |=> res_data < 10'h1ff)
		else $error("top");
	a_nom_span:
		assert property (req_valid && req_comp && req_raw inside {[64:960]}
		|=> res_data != 10'h000) else $error("nom");
	sequence s_req_above;
		req_valid && req_comp && req_raw > 10'h3e0;
	endsequence
	sequence s_err_out;
		res_err_high && res_data == 10'h000;
	endsequence
	a_err_high:
		assert property (s_req_above |=> s_err_out) else $error("err high");
endmodule : srrc_monitor
bind srrc_clamp srrc_monitor mon (.*);
`default_nettype wire

/* bench/srrc_conv_model.sv */
`default_nettype none
module srrc_conv_model (
	input  wire logic [9:0] level,
	output logic [9:0]      code
);
	timeunit 1ns;
	timeprecision 100ps;
	assign code = level;
endmodule : srrc_conv_model
`default_nettype wire

/* bench/test_srrc_clamp.sv */
`default_nettype none
module test_srrc_clamp;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk        = 1'b0;
	logic        arst_n     = 1'b0;
	logic        req_valid  = 1'b0;
	logic        req_comp   = 1'b0;
	logic        coef_we    = 1'b0;
	logic        coef_erase = 1'b0;
	logic [9:0]  lvl        = 10'h000;
	logic [8:0]  coef_addr  = 9'h000;
	logic [7:0]  coef_wdata = 8'h00;
	logic [9:0]  req_raw;
	logic [7:0]  coef_rdata;
	logic        res_valid;
	logic [9:0]  res_data;
	logic        res_err_low;
	logic        res_err_high;
	logic        res_underflow;
	logic        res_overflow;
	logic        res_nominal;
	logic [14:0] got;
	logic [15:0] rng = 16'h003c;
	logic [14:0] expq [$];
	logic [7:0]  cb [4] = '{8'h00, 8'h01, 8'hc0, 8'hff};
	logic [9:0]  r;
	logic        m;
	int          errors  = 0;
	int          checked = 0;
	int          i;
	srrc_conv_model ADC (.level(lvl), .code(req_raw));
	srrc_clamp DUT (
		.clk           (clk),
		.arst_n        (arst_n),
		.req_valid     (req_valid),
		.req_raw       (req_raw),
		.req_comp      (req_comp),
		.coef_we       (coef_we),
		.coef_erase    (coef_erase),
		.coef_addr     (coef_addr),
		.coef_wdata    (coef_wdata),
		.coef_rdata    (coef_rdata),
		.res_valid     (res_valid),
		.res_data      (res_data),
		.res_err_low   (res_err_low),
		.res_err_high  (res_err_high),
		.res_underflow (res_underflow),
		.res_overflow  (res_overflow),
		.res_nominal   (res_nominal)
	);
	assign got = {res_err_low, res_err_high, res_underflow,
		res_overflow, res_nominal, res_data};
	initial forever #12.5 clk = ~clk;
	function automatic logic [15:0] xorshift(input logic [15:0] s);
		logic [15:0] t;
		t = s ^ (s << 7);
		t = t ^ (t >> 9);
		return t ^ (t << 8);
	endfunction : xorshift
	task automatic report_and_stop;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : report_and_stop
	// gain 1.0 and offset -64: both saturations reachable
	// note packs {err_low, err_high, underflow, overflow, nominal, data}
	function automatic logic [14:0] want(
		input logic [9:0] rv,
		input logic       mv
	);
		int   c;
		logic el;
		logic eh;
		logic nom;
		c   = int'(rv) - 64;
		el  = rv < srrc_pkg::IN_MIN_DEF;
		eh  = rv > srrc_pkg::IN_MAX_DEF;
		nom = rv >= srrc_pkg::IN_LO_DEF && rv <= srrc_pkg::IN_HI_DEF;
		if (!mv) return {el, eh, 2'b00, nom, rv};
		if (el || eh) return {el, eh, 2'b00, nom, 10'h000};
		if (c < 1) return {el, eh, 2'b10, nom, 10'h001};
		if (c > 510) return {el, eh, 2'b01, nom, {1'b0, srrc_pkg::CODE_HIGH}};
		return {el, eh, 2'b00, nom, 10'(c)};
	endfunction : want
	// sampled at the falling edge, well clear of the launching edge
	always @(negedge clk) begin
		if (arst_n === 1'b1 && res_valid === 1'b1) begin
			checked++;
			if (expq.size() == 0) begin
				errors++;
				$display("ERROR %0t result without request", $time);
			end else begin
				if (got !== expq[0]) begin
					errors++;
					$display("ERROR %0t result mismatch", $time);
				end
				void'(expq.pop_front());
			end
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		for (i = 0; i < 4; i++) begin
			@(posedge clk);
			coef_we    <= 1'b1;
			coef_addr  <= 9'(i);
			coef_wdata <= cb[i];
		end
		@(posedge clk);
		coef_we    <= 1'b0;
		coef_erase <= 1'b1;
		@(posedge clk);
		coef_erase <= 1'b0;
		coef_addr  <= 9'h002;
		repeat (2) @(posedge clk);
		@(negedge clk);
		checked++;
		if (coef_rdata !== 8'hc0) begin
			errors++;
			$display("ERROR %0t coefficient lost", $time);
		end
		$display("coefficient test done");
		for (i = 0; i < 600; i++) begin
			@(posedge clk);
			rng = xorshift(rng);
			r   = i < 8 ? 10'h01c + 10'(i) : rng[9:0];
			m   = i < 8 || rng[10];
			req_valid <= 1'b1;
			lvl       <= r;
			req_comp  <= m;
			expq.push_back(want(r, m));
		end
		@(posedge clk);
		req_valid <= 1'b0;
		for (i = 0; i < 20 && expq.size() > 0; i++) @(posedge clk);
		if (expq.size() > 0) begin
			errors++;
			$display("ERROR %0t results missing", $time);
		end
		$display("stream test done");
		report_and_stop();
	end
endmodule : test_srrc_clamp
`default_nettype wire
